// ---- logic/imsq_pkg.sv ----
// constants, types and field layout of the two-wire master sequencer
// assumes a single clk domain and an Avalon-MM slave with waitrequest
package imsq_pkg;
   // register byte offsets
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] BUF_OFS  = 4'h4;
   localparam logic [3:0] ADDR_OFS = 4'h8;
   localparam logic [3:0] STAT_OFS = 4'hc;
   // port_control_two fields
   localparam int START_EN_BIT = 0;
   localparam int RESTART_BIT  = 1;
   localparam int STOP_EN_BIT  = 2;
   localparam int RECV_BIT     = 3;
   localparam int ACK_DATA_BIT = 4;
   localparam int ACK_STAT_BIT = 6;
   // status fields
   localparam int FLAG_BIT = 0;
   localparam int BUSY_BIT = 1;
   // reset values and counts
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [3:0] LAST_BIT   = 4'h8;
   localparam int         BRG_DIV    = 4;
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_RESTART, ST_START, ST_BITS, ST_HOLD, ST_STOP
   } imsq_state_type;
   // open-drain pin drive bundle
   typedef struct packed {
      logic scl_out;
      logic scl_oe;
      logic sda_out;
      logic sda_oe;
   } imsq_pins_type;
endpackage

// ---- logic/imsq_top.sv ----
// two-wire bus master sequencer with Avalon-MM register slave
// assumes pins resolved outside (wired-and), inputs synchronous to clk
`timescale 1ns/10ps
module imsq_top #(
   parameter int DIV = imsq_pkg::BRG_DIV  // clk cycles per reload step
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   // avalon-mm slave
   input  wire logic [3:0]             address,
   input  wire logic                   read,
   input  wire logic                   write,
   input  wire logic [3:0]             byteenable,
   input  wire logic [31:0]            writedata,
   output logic      [31:0]            readdata,
   output logic                        waitrequest,
   // two-wire bus
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output imsq_pkg::imsq_pins_type     pins
);
   import imsq_pkg::*;

   if (DIV < 1 || DIV > 4) begin : g_chk
      $error("DIV must lie in 1..4");
   end

   // register selection by word offset
   function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
      return a[3:2] == o[3:2];
   endfunction

   // pin levels per state and quarter: {scl_high, sda_high}
   function automatic logic [1:0] lvl(input imsq_state_type s,
                                      input logic [1:0] q, input logic b);
      case (s)
         ST_IDLE:    lvl = 2'h3;
         ST_RESTART: lvl = 2'h1;
         ST_START:   lvl = (q == 2'h0) ? 2'h3 : (q == 2'h3) ? 2'h0 : 2'h2;
         ST_BITS:    lvl = {q[1], b};
         ST_HOLD:    lvl = 2'h1;
         ST_STOP:    lvl = (q == 2'h0) ? 2'h0 : (q == 2'h3) ? 2'h3 : 2'h2;
         default:    lvl = 2'h3;
      endcase
   endfunction

   imsq_state_type state_ff, nxt_state_ff;  // sequencer state
   logic [1:0]  q_ff, nxt_q_ff;             // quarter of bit time
   logic [9:0]  cnt_ff, nxt_cnt_ff;         // baud counter
   logic [3:0]  bit_ff, nxt_bit_ff;         // bit index 0..8
   logic [8:0]  tx_ff, nxt_tx_ff;           // outgoing bits, msb first
   logic [7:0]  rx_ff, nxt_rx_ff;           // received byte
   logic [7:0]  reload_ff, nxt_reload_ff;   // address_or_baud_reload
   logic        ack_stat_ff, nxt_ack_stat_ff;
   logic        ack_data_ff, nxt_ack_data_ff;
   logic        rd_mode_ff, nxt_rd_mode_ff; // current byte is a receive
   logic        addr_ph_ff, nxt_addr_ph_ff; // next load is the address
   logic        dir_ff, nxt_dir_ff;         // direction of transfer
   logic        flag_ff, nxt_flag_ff;       // port_interrupt_flag
   logic [1:0]  lvl_ff, nxt_lvl_ff;         // registered pin levels
   logic        served_ff, nxt_served_ff;   // bus wait state done
   logic [31:0] rdata_ff, nxt_rdata_ff;     // read data
   logic [9:0]  limit;                      // last count of a quarter
   logic        tick;                       // quarter ends
   logic        wr_ok;                      // write taken this edge
   logic        flag_set;                   // hardware event

   // quarter length is DIV*(reload+1) clocks
   assign limit = 10'((DIV * (int'(reload_ff) + 1)) - 1);
   assign tick  = (cnt_ff == limit);
   assign wr_ok = write & served_ff & byteenable[0];

   // one wait state per access; waitrequest low on the taking edge
   assign waitrequest = (read | write) & ~served_ff;
   assign readdata    = rdata_ff;

   // open drain: only ever pull low
   assign pins.scl_out = 1'b0;
   assign pins.sda_out = 1'b0;
   assign pins.scl_oe  = ~lvl_ff[1];
   assign pins.sda_oe  = ~lvl_ff[0];

   // bus slave: wait state and read data
   always_comb begin
      nxt_served_ff = (read | write) & ~served_ff;
      nxt_rdata_ff  = rdata_ff;
      if (read & ~served_ff) begin
         nxt_rdata_ff = 32'h0; // unused bits read zero
         if (hit(address, CTRL_OFS)) begin
            nxt_rdata_ff[ACK_STAT_BIT] = ack_stat_ff;
            nxt_rdata_ff[ACK_DATA_BIT] = ack_data_ff;
            nxt_rdata_ff[START_EN_BIT] = state_ff == ST_START;
            nxt_rdata_ff[RESTART_BIT]  = state_ff == ST_RESTART;
            nxt_rdata_ff[STOP_EN_BIT]  = state_ff == ST_STOP;
            nxt_rdata_ff[RECV_BIT]     = (state_ff == ST_BITS) & rd_mode_ff;
         end else if (hit(address, BUF_OFS)) begin
            nxt_rdata_ff[7:0] = rx_ff;
         end else if (hit(address, ADDR_OFS)) begin
            nxt_rdata_ff[7:0] = reload_ff;
         end else if (hit(address, STAT_OFS)) begin
            nxt_rdata_ff[FLAG_BIT] = flag_ff;
            nxt_rdata_ff[BUSY_BIT] = (state_ff != ST_IDLE) & (state_ff != ST_HOLD);
         end
      end
   end

   // sequencer next state
   always_comb begin
      nxt_state_ff    = state_ff;
      nxt_q_ff        = q_ff;
      nxt_cnt_ff      = 10'h0;
      nxt_bit_ff      = bit_ff;
      nxt_tx_ff       = tx_ff;
      nxt_rx_ff       = rx_ff;
      nxt_reload_ff   = reload_ff;
      nxt_ack_stat_ff = ack_stat_ff;
      nxt_ack_data_ff = ack_data_ff;
      nxt_rd_mode_ff  = rd_mode_ff;
      nxt_addr_ph_ff  = addr_ph_ff;
      nxt_dir_ff      = dir_ff;
      flag_set        = 1'b0;
      // shared register: reload value in master use
      if (wr_ok & hit(address, ADDR_OFS)) begin
         nxt_reload_ff = writedata[7:0];
      end
      if (wr_ok & hit(address, CTRL_OFS)) begin
         nxt_ack_data_ff = writedata[ACK_DATA_BIT];
      end
      // counter runs only while a condition or bit is timed
      if ((state_ff != ST_IDLE) && (state_ff != ST_HOLD) && !tick) begin
         nxt_cnt_ff = cnt_ff + 10'h1;
      end
      case (state_ff)
         ST_IDLE: begin
            // only a start is accepted on an idle bus
            if (wr_ok & hit(address, CTRL_OFS) & writedata[START_EN_BIT]) begin
               nxt_state_ff = ST_START;
               nxt_q_ff     = 2'h0;
            end
         end
         ST_HOLD: begin
            // clock held low until software acts
            if (wr_ok & hit(address, BUF_OFS)) begin
               nxt_tx_ff      = {writedata[7:0], 1'b1};
               nxt_rd_mode_ff = 1'b0;
               nxt_state_ff   = ST_BITS;
               nxt_bit_ff     = 4'h0;
               nxt_q_ff       = 2'h0;
               nxt_addr_ph_ff = 1'b0;
               if (addr_ph_ff) begin
                  nxt_dir_ff = writedata[0];
               end
            end else if (wr_ok & hit(address, CTRL_OFS)) begin
               if (writedata[STOP_EN_BIT]) begin
                  nxt_state_ff = ST_STOP;
                  nxt_q_ff     = 2'h0;
               end else if (writedata[RESTART_BIT]) begin
                  nxt_state_ff = ST_RESTART;
                  nxt_q_ff     = 2'h0;
               end else if (writedata[RECV_BIT] & dir_ff & ~addr_ph_ff) begin
                  // release data for eight bits, then drive acknowledge
                  nxt_tx_ff      = {8'hff, writedata[ACK_DATA_BIT]};
                  nxt_ack_data_ff = writedata[ACK_DATA_BIT];
                  nxt_rd_mode_ff = 1'b1;
                  nxt_state_ff   = ST_BITS;
                  nxt_bit_ff     = 4'h0;
                  nxt_q_ff       = 2'h0;
               end
            end
         end
         ST_RESTART: begin
            // release data with clock low, then run a start
            if (tick) begin
               nxt_state_ff = ST_START;
            end
         end
         ST_START: begin
            if (tick) begin
               nxt_q_ff = q_ff + 2'h1;
               if (q_ff == 2'h3) begin
                  nxt_state_ff   = ST_HOLD;
                  nxt_addr_ph_ff = 1'b1;
                  flag_set       = 1'b1;
               end
            end
         end
         ST_BITS: begin
            if (tick) begin
               nxt_q_ff = q_ff + 2'h1;
               // sample in the middle of clock high
               if (q_ff == 2'h2) begin
                  if (bit_ff != LAST_BIT) begin
                     nxt_rx_ff = {rx_ff[6:0], sda_in};
                  end else if (!rd_mode_ff) begin
                     nxt_ack_stat_ff = sda_in;
                  end
               end
               if (q_ff == 2'h3) begin
                  if (bit_ff == LAST_BIT) begin
                     nxt_state_ff = ST_HOLD;
                     flag_set     = 1'b1;
                  end else begin
                     nxt_bit_ff = bit_ff + 4'h1;
                     nxt_tx_ff  = {tx_ff[7:0], 1'b1};
                  end
               end
            end
         end
         ST_STOP: begin
            if (tick) begin
               nxt_q_ff = q_ff + 2'h1;
               if (q_ff == 2'h3) begin
                  nxt_state_ff = ST_IDLE;
                  flag_set     = 1'b1;
               end
            end
         end
         default: nxt_state_ff = ST_IDLE;
      endcase
      // pins follow the next state; data moves only with clock low, except in start and stop
      nxt_lvl_ff = lvl(nxt_state_ff, nxt_q_ff, nxt_tx_ff[8]);
      // falling clock keeps data one more cycle: a data edge on the
      // same edge as the clock could read as a start or stop
      if (lvl_ff[1] & ~nxt_lvl_ff[1]) begin
         nxt_lvl_ff[0] = lvl_ff[0];
      end
      // a set in the same cycle as a clear wins
      nxt_flag_ff = flag_set | (flag_ff &
                    ~(wr_ok & hit(address, STAT_OFS) & writedata[FLAG_BIT]));
   end

   // register all state
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff    <= ST_IDLE;
         q_ff        <= 2'h0;
         cnt_ff      <= 10'h0;
         bit_ff      <= 4'h0;
         tx_ff       <= 9'h1ff;
         rx_ff       <= 8'h00;
         reload_ff   <= RELOAD_RST;
         ack_stat_ff <= 1'b0;
         ack_data_ff <= 1'b0;
         rd_mode_ff  <= 1'b0;
         addr_ph_ff  <= 1'b0;
         dir_ff      <= 1'b0;
         flag_ff     <= 1'b0;
         lvl_ff      <= 2'h3;
         served_ff   <= 1'b0;
         rdata_ff    <= 32'h0;
      end else begin
         state_ff    <= nxt_state_ff;
         q_ff        <= nxt_q_ff;
         cnt_ff      <= nxt_cnt_ff;
         bit_ff      <= nxt_bit_ff;
         tx_ff       <= nxt_tx_ff;
         rx_ff       <= nxt_rx_ff;
         reload_ff   <= nxt_reload_ff;
         ack_stat_ff <= nxt_ack_stat_ff;
         ack_data_ff <= nxt_ack_data_ff;
         rd_mode_ff  <= nxt_rd_mode_ff;
         addr_ph_ff  <= nxt_addr_ph_ff;
         dir_ff      <= nxt_dir_ff;
         flag_ff     <= nxt_flag_ff;
         lvl_ff      <= nxt_lvl_ff;
         served_ff   <= nxt_served_ff;
         rdata_ff    <= nxt_rdata_ff;
      end
   end

   // checks on the sequencer
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_idle_free;
      state_ff == ST_IDLE && $past(state_ff) == ST_IDLE |-> !pins.scl_oe && !pins.sda_oe;
   endproperty
   a_idle_free: assert property (p_idle_free) else $error("bus held idle");

   property p_sda_stable;
      state_ff == ST_BITS && !pins.scl_oe && $past(!pins.scl_oe) |-> $stable(pins.sda_oe);
   endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved, clock high");

   property p_byte_flag;
      state_ff == ST_BITS && bit_ff == LAST_BIT && q_ff == 2'h3 && tick
         |=> flag_ff && state_ff == ST_HOLD;
   endproperty
   a_byte_flag: assert property (p_byte_flag) else $error("no flag after ninth clock");

   property p_stop_flag;
      state_ff == ST_STOP && q_ff == 2'h3 && tick |=> flag_ff && state_ff == ST_IDLE;
   endproperty
   a_stop_flag: assert property (p_stop_flag) else $error("no flag after stop");

   property p_start_flag;
      state_ff == ST_START && q_ff == 2'h3 && tick |=> flag_ff ##0 addr_ph_ff;
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("no flag after start");

   property p_ack_cap;
      state_ff == ST_BITS && bit_ff == LAST_BIT && q_ff == 2'h2 && tick && !rd_mode_ff
         |=> ack_stat_ff == $past(sda_in);
   endproperty
   a_ack_cap: assert property (p_ack_cap) else $error("acknowledge not stored");

   property p_load;
      state_ff == ST_HOLD && wr_ok && hit(address, BUF_OFS)
         |=> state_ff == ST_BITS && bit_ff == 4'h0 && tx_ff[8:1] == $past(writedata[7:0]);
   endproperty
   a_load: assert property (p_load) else $error("byte not launched");

   property p_brg;
      cnt_ff <= limit;
   endproperty
   a_brg: assert property (p_brg) else $error("baud count overran");

   property p_reload_rst;
      $past(rst) |-> reload_ff == RELOAD_RST;
   endproperty
   a_reload_rst: assert property (p_reload_rst) else $error("reload not cleared");

   c_start: cover property (state_ff == ST_START ##1 state_ff == ST_HOLD);
   c_ack:   cover property (state_ff == ST_BITS ##1 state_ff == ST_HOLD && !ack_stat_ff);
   c_rstrt: cover property (state_ff == ST_RESTART);
   c_stop:  cover property (state_ff == ST_STOP ##1 state_ff == ST_IDLE);
endmodule

// ---- dv/imsq_slave.sv ----
// two-wire slave model: acks bytes it receives, returns one byte on reads
// assumes resolved open-drain lines with a pull-up on the data line
`timescale 1ns/10ps
module imsq_slave (
   // resolved bus lines
   input  wire logic       scl,
   input  wire logic       sda,
   // bench controls
   input  wire logic [7:0] tx_data,
   input  wire logic       ack_en,
   // observed results
   output logic            pull,
   output logic [7:0]      rx_byte,
   output logic            m_ack
);
   int         n;      // rising clocks seen in this byte
   logic [7:0] sh;     // incoming shift register
   logic       rd;     // current transfer is a read
   logic       first;  // next byte is the address byte
   initial begin
      n = 0;
      pull = 0;
      rd = 0;
      first = 0;
      sh = 8'h00;
      rx_byte = 8'h00;
      m_ack = 1'b0;
   end
   // start or repeated start restarts byte framing
   always @(negedge sda) if (scl) begin
      n = 0;
      first = 1;
      pull = 0;
      m_ack = 1'b0;
   end
   // data is taken while the clock is high
   always @(posedge scl) begin
      sh = {sh[6:0], sda};
      n = n + 1;
      if (n == 9 && rd && !first) m_ack = sda;
   end
   // the model only changes the data line while the clock is low
   always @(negedge scl) begin
      pull = 0;
      if (n == 8 && !(rd && !first)) begin
         if (first) rd = sh[0];
         rx_byte = sh;
         pull = ack_en;
      end else if (n == 9) begin
         n = 0;
         first = 0;
         // stop sending once the master refuses a byte
         pull = rd & ~m_ack & ~tx_data[7];
      end else if (rd && !first && n < 8) pull = ~tx_data[7 - n];
   end
endmodule

// ---- dv/tb_imsq_top.sv ----
// bench for the two-wire master sequencer: registers and bus transfers
// assumes the slave model on the resolved lines and one-wait avalon access
`timescale 1ns/10ps
module tb_imsq_top;
   import imsq_pkg::*;
   localparam int D = 2;              // shortened reload step
   logic          clk, rst, read, write, waitrequest, pull, m_ack, ack_en;
   logic [3:0]    address;
   logic [31:0]   writedata, readdata, q;
   logic [7:0]    rx_byte, tx_data, b;
   logic [7:0]    rl[2] = '{8'h00, 8'h02};  // reload values tried
   logic [7:0]    exp_q[$];           // bytes the slave should see
   imsq_pins_type pins;
   int            err_count, comparisons, cyc, per;
   time           tp;
   // open-drain lines, pulled up when nobody pulls low
   wire scl = ~pins.scl_oe;
   wire sda = ~(pins.sda_oe | pull);
   imsq_top #(.DIV(D)) dut (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .scl_in(scl), .sda_in(sda), .pins(pins));
   imsq_slave slv (.scl(scl), .sda(sda), .tx_data(tx_data), .ack_en(ack_en),
      .pull(pull), .rx_byte(rx_byte), .m_ack(m_ack));
   initial begin
      clk = 0;
      forever #4 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         print_verdict();
      end
   end
   // clock period in clk cycles, wall time avoids edge races
   always @(posedge scl) begin
      per = int'(($time - tp) / 8);
      tp = $time;
   end
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one avalon access, held until waitrequest is low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      address <= a;
      writedata <= {24'h0, d};
      write <= wr;
      read <= ~wr;
      // values read here are those before this edge's updates land
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clk);
   endtask
   // poll the flag, then clear it by writing one
   task automatic wait_flag();
      int k;
      k = 0;
      do begin
         bus(0, STAT_OFS, 8'h00);
         k++;
      end while (q[FLAG_BIT] !== 1'b1 && k < 400);
      chk(32'(q[FLAG_BIT]), 32'h1);
      bus(1, STAT_OFS, 8'h01);
   endtask
   // send one byte, compare what the slave took and the ack status
   task automatic send(input logic [7:0] v, input logic ak);
      exp_q.push_back(v);
      bus(1, BUF_OFS, v);
      wait_flag();
      chk(32'(rx_byte), 32'(exp_q.pop_front()));
      bus(0, CTRL_OFS, 8'h00);
      chk(32'(q[ACK_STAT_BIT]), 32'(ak));
   endtask
   initial begin
      rst = 1;
      read = 0;
      write = 0;
      address = 4'h0;
      writedata = 32'h0;
      cyc = 0;
      tp = 0;
      err_count = 0;
      comparisons = 0;
      tx_data = 8'h00;
      ack_en = 1;
      void'($urandom(32'h78fb));
      repeat (16) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      // shared register reset value and read back
      bus(0, ADDR_OFS, 8'h00);
      chk(q, {24'h0, RELOAD_RST});
      b = 8'($urandom);
      bus(1, ADDR_OFS, b);
      bus(0, ADDR_OFS, 8'h00);
      chk(q, {24'h0, b});
      // write transfers at two bus rates
      foreach (rl[i]) begin
         bus(1, ADDR_OFS, rl[i]);
         bus(1, CTRL_OFS, 8'h01);
         wait_flag();
         send(8'h54, 1'b0);
         send(8'($urandom), 1'b0);
         chk(32'(per), 32'(4 * D * (rl[i] + 1)));
         bus(1, CTRL_OFS, 8'h04);
         wait_flag();
         chk({30'h0, scl, sda}, 32'h3);
      end
      // buffer load during start is ignored, then a refused address
      ack_en = 0;
      bus(1, CTRL_OFS, 8'h01);
      bus(1, BUF_OFS, 8'hff);
      bus(0, STAT_OFS, 8'h00);
      chk(32'(q[BUSY_BIT]), 32'h1);
      wait_flag();
      send(8'h54, 1'b1);
      bus(1, CTRL_OFS, 8'h04);
      wait_flag();
      // read two bytes, acknowledge then refuse, repeated start into a write
      ack_en = 1;
      tx_data = 8'($urandom);
      bus(1, CTRL_OFS, 8'h01);
      wait_flag();
      send(8'h55, 1'b0);
      bus(1, CTRL_OFS, 8'h08);
      wait_flag();
      chk(32'(m_ack), 32'h0);
      bus(0, BUF_OFS, 8'h00);
      chk(q, {24'h0, tx_data});
      bus(1, CTRL_OFS, 8'h18);
      wait_flag();
      bus(0, BUF_OFS, 8'h00);
      chk(q, {24'h0, tx_data});
      chk(32'(m_ack), 32'h1);
      bus(1, CTRL_OFS, 8'h02);
      wait_flag();
      send(8'h54, 1'b0);
      bus(1, CTRL_OFS, 8'h04);
      wait_flag();
      chk({30'h0, scl, sda}, 32'h3);
      print_verdict();
   end
endmodule
